// File: eeprom_read_and_ack_polling.sv
// i2c eeprom target: reads, acknowledge polling, ecc groups and write cycle timing
//
// Behaviour
// - while the write cycle runs, refuse select codes; acknowledge once it ends
// - after chip-enable change, acknowledge only matching new bits and cycle done
// - error correction code covers aligned four-byte groups
// - single bit error inside a group is corrected silently on read
// - writing one byte rewrites the whole group with fresh code
// - random read: write select, two address bytes, repeated start, read select
// - no acknowledge after a data byte ends output; standby after stop
// - address counter advances by one after every byte read
// - dummy write loads the counter and is followed by repeated start
// - current read: acknowledge, send byte at counter, then increment counter
// - acknowledged byte makes the device send the next consecutive byte
// - counter wraps past the top address to zero
// - any two-byte addressed access loads the shared counter
// - write cycle starts on stop right after the data acknowledge, or on an accepted chip-enable load
`timescale 1ns/10ps
module eeprom_read_and_ack_polling #(
  parameter int WRITE_TIME_NS = 1000000
) (
  // system clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 reset,
  // link sampling clock
  input  wire logic                 link_clk,
  // serial bus pins
  input  wire logic                 scl_in,
  input  wire logic                 sda_in,
  output logic                      sda_out,
  output logic                      sda_oe,
  // chip-enable reconfiguration from configuration logic on ref_clk
  input  wire logic                 ce_load,
  input  wire eeprom_rd_pkg::ce_type ce_value,
  // status
  output logic                      write_busy
);
  import eeprom_rd_pkg::*;

  localparam int RAW_CYCLES   = WRITE_TIME_NS / REF_CLK_PERIOD_NS;
  localparam int WRITE_CYCLES = RAW_CYCLES < MIN_WRITE_CYCLES ? MIN_WRITE_CYCLES : RAW_CYCLES;

  typedef enum logic [2:0] {
    st_idle, st_select, st_addr_hi, st_addr_lo, st_data, st_read, st_ignore
  } link_state_type;

  function automatic logic [CHECK_W-1:0] syndrome(input logic [CODE_W-1:0] cw);
    logic [CHECK_W-1:0] s;
    s = '0;
    for (int i = 0; i < CODE_W; i++) begin
      if (cw[i]) s = s ^ CHECK_W'(i + 1);
    end
    return s;
  endfunction

  function automatic logic [CODE_W-1:0] ecc_encode(input logic [DATA_W-1:0] d);
    logic [CODE_W-1:0]  cw;
    logic [CHECK_W-1:0] s;
    int                 k;
    cw = '0;
    k = 0;
    for (int i = 0; i < CODE_W; i++) begin
      if (((i + 1) & i) != 0) begin
        cw[i] = d[k];
        k++;
      end
    end
    s = syndrome(cw);
    for (int j = 0; j < CHECK_W; j++) begin
      cw[(1 << j) - 1] = s[j];
    end
    return cw;
  endfunction

  // a syndrome that points outside the word is a multi-bit error; data passes as stored
  function automatic logic [DATA_W-1:0] ecc_decode(input logic [CODE_W-1:0] cw_in);
    logic [CODE_W-1:0]  cw;
    logic [CHECK_W-1:0] s;
    logic [DATA_W-1:0]  d;
    int                 k;
    cw = cw_in;
    s = syndrome(cw_in);
    d = '0;
    k = 0;
    if (s != '0 && int'(s) <= CODE_W) cw[int'(s) - 1] = ~cw[int'(s) - 1];
    for (int i = 0; i < CODE_W; i++) begin
      if (((i + 1) & i) != 0) begin
        d[k] = cw[i];
        k++;
      end
    end
    return d;
  endfunction

  // ---------------- ref_clk domain: array, ecc, write cycle ----------------
  logic [CODE_W-1:0] mem [GROUPS];
  logic              req_meta;
  logic              req_sync;
  logic              req_seen;
  logic              ack_tgl;
  logic [DATA_W-1:0] rdata;
  logic [31:0]       timer;
  ce_type            ce_cur;
  ce_type            ce_pend;
  link_req_type      req;
  logic              req_tgl;

  wire                    req_new   = req_sync != req_seen;
  wire                    do_write  = req_new && req.wr;
  wire                    do_read   = req_new && !req.wr;
  wire                    ce_accept = ce_load && !write_busy && !do_write;
  wire [ADDR_W-3:0]       grp_index = req.addr[ADDR_W-1:2];
  wire [CODE_W-1:0]       grp_code  = mem[grp_index];
  wire [DATA_W-1:0]       grp_data  = ecc_decode(grp_code);
  wire [DATA_W-1:0]       merged;

  generate
    for (genvar g = 0; g < 4; g++) begin : lane
      assign merged[8*g +: 8] = (req.addr[1:0] == 2'(g)) ? req.data : grp_data[8*g +: 8];
    end
  endgenerate

  initial begin
    for (int i = 0; i < GROUPS; i++) begin
      mem[i] = ecc_encode(ERASED_WORD);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (do_write) begin
      mem[grp_index] <= ecc_encode(merged);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      req_meta   <= 1'b0;
      req_sync   <= 1'b0;
      req_seen   <= 1'b0;
      ack_tgl    <= 1'b0;
      rdata      <= '0;
      write_busy <= 1'b0;
      timer      <= '0;
      ce_cur     <= CE_RESET;
      ce_pend    <= CE_RESET;
    end else begin
      req_meta <= req_tgl;
      req_sync <= req_meta;
      if (req_new) begin
        req_seen <= req_sync;
        ack_tgl  <= ~ack_tgl;
      end
      if (do_read) begin
        rdata <= grp_data;
      end
      if (ce_accept) begin
        ce_pend <= ce_value;
      end
      if (do_write || ce_accept) begin
        write_busy <= 1'b1;
        timer      <= 32'(WRITE_CYCLES - 1);
      end else if (write_busy) begin
        timer <= timer - 32'h1;
        // new chip-enable bits land one cycle before busy drops, so the link never
        // sees ready together with the old bits
        if (timer == 32'h1) begin
          ce_cur <= ce_pend;
        end
        if (timer == 32'h0) begin
          write_busy <= 1'b0;
        end
      end
    end
  end

  // ---------------- link_clk domain: bus protocol ----------------
  link_state_type state;
  logic           link_rst_meta;
  logic           link_rst;
  logic           scl_meta;
  logic           scl_s;
  logic           scl_d;
  logic           sda_meta;
  logic           sda_s;
  logic           sda_d;
  logic           busy_meta;
  logic           busy_s;
  ce_type         ce_meta;
  ce_type         ce_s;
  logic           ack_meta;
  logic           ack_s;
  logic [3:0]     cnt;
  logic [7:0]     shreg;
  logic [7:0]     addr_hi;
  logic           sel_a16;
  logic [ADDR_W-1:0] addr;
  logic           wr_ok;

  wire       scl_rise  = scl_s && !scl_d;
  wire       scl_fall  = !scl_s && scl_d;
  wire       start_ev  = scl_s && scl_d && sda_d && !sda_s;
  wire       stop_ev   = scl_s && scl_d && !sda_d && sda_s;
  wire       rdy       = ack_s == req_tgl;
  wire       rx_state  = state inside {st_select, st_addr_hi, st_addr_lo, st_data};
  wire       rx_decide = rx_state && scl_fall && cnt == ACK_SLOT;
  wire       rx_done   = rx_state && scl_fall && cnt == ACK_DONE;
  wire       rd_rise   = state == st_read && scl_rise;
  wire       type_ok   = shreg[SEL_TYPE_LSB +: 4] == DEVICE_TYPE;
  wire       ce_ok     = shreg[SEL_CE_LSB +: 2] == ce_s;
  wire       sel_ok    = type_ok && ce_ok && !busy_s && rdy;
  wire       take      = state != st_select || sel_ok;
  wire       rw        = shreg[SEL_RW_BIT];
  wire [7:0] tx_byte   = rdata[8*req.addr[1:0] +: 8];
  wire       tx_bit    = tx_byte[~cnt[2:0]];
  wire       drive_bit = cnt < ACK_SLOT && rdy && !tx_bit;
  wire [ADDR_W-1:0] load_addr = {sel_a16, addr_hi, shreg};
  link_state_type next_rx;

  assign next_rx = (state == st_select) ? (rw ? st_read : st_addr_hi) :
                   (state == st_addr_hi) ? st_addr_lo :
                   (state == st_addr_lo) ? st_data : st_ignore;

  always_ff @(posedge link_clk) begin
    link_rst_meta <= reset;
    link_rst      <= link_rst_meta;
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      {scl_meta, scl_s, scl_d, sda_meta, sda_s, sda_d} <= 6'h3f;
      {busy_meta, busy_s, ack_meta, ack_s} <= 4'h0;
      ce_meta <= CE_RESET;
      ce_s    <= CE_RESET;
    end else begin
      scl_meta  <= scl_in;
      scl_s     <= scl_meta;
      scl_d     <= scl_s;
      sda_meta  <= sda_in;
      sda_s     <= sda_meta;
      sda_d     <= sda_s;
      busy_meta <= write_busy;
      busy_s    <= busy_meta;
      ce_meta   <= ce_cur;
      ce_s      <= ce_meta;
      ack_meta  <= ack_tgl;
      ack_s     <= ack_meta;
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      state   <= st_idle;
      cnt     <= 4'h0;
      shreg   <= 8'h00;
      addr_hi <= 8'h00;
      sel_a16 <= 1'b0;
      addr    <= '0;
      req     <= '0;
      req_tgl <= 1'b0;
      wr_ok   <= 1'b0;
      sda_oe  <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      // the stop's own clock rise keeps the write armed; a full pulse after the ack cancels it
      if (scl_fall) begin
        wr_ok <= 1'b0;
      end
      if (start_ev) begin
        state  <= st_select;
        cnt    <= 4'h0;
        sda_oe <= 1'b0;
        wr_ok  <= 1'b0;
      end else if (stop_ev) begin
        state  <= st_idle;
        sda_oe <= 1'b0;
        wr_ok  <= 1'b0;
        if (wr_ok) begin
          req_tgl <= ~req_tgl;
        end
      end else if (rx_state && scl_rise) begin
        if (cnt < ACK_SLOT) begin
          shreg <= {shreg[6:0], sda_s};
        end
        cnt   <= cnt + 4'h1;
        wr_ok <= 1'b0;
      end else if (rx_decide) begin
        sda_oe <= take;
        if (!take) begin
          state <= st_ignore;
        end
        case (state)
          st_select: begin
            sel_a16 <= shreg[SEL_A16_BIT];
            if (sel_ok && rw) begin
              req     <= '{wr: 1'b0, addr: addr, data: 8'h00};
              req_tgl <= ~req_tgl;
            end
          end
          st_addr_hi: addr_hi <= shreg;
          st_addr_lo: addr <= load_addr;
          st_data: req <= '{wr: 1'b1, addr: addr, data: shreg};
          default: ;
        endcase
      end else if (rx_done) begin
        sda_oe <= 1'b0;
        cnt    <= 4'h0;
        state  <= next_rx;
        wr_ok  <= state == st_data;
      end else if (rd_rise) begin
        if (cnt == ACK_SLOT) begin
          if (sda_s) begin
            state <= st_ignore;
          end else begin
            cnt     <= 4'h0;
            req     <= '{wr: 1'b0, addr: addr, data: 8'h00};
            req_tgl <= ~req_tgl;
          end
        end else begin
          cnt <= cnt + 4'h1;
          if (cnt == LAST_BIT) begin
            addr <= addr + 17'h1;
          end
        end
      end else if (state == st_read && !scl_s) begin
        sda_oe <= drive_bit;
      end
    end
  end

  a_busy_refuse: assert property (@(posedge link_clk) disable iff (link_rst)
    rx_decide && state == st_select && busy_s |=> state == st_ignore && !sda_oe)
    else $error("select acknowledged during write cycle");
  a_ready_accept: assert property (@(posedge link_clk) disable iff (link_rst)
    rx_decide && state == st_select && sel_ok |=> sda_oe ##1 sda_oe)
    else $error("ready device did not acknowledge select");
  a_ce_mismatch: assert property (@(posedge link_clk) disable iff (link_rst)
    rx_decide && state == st_select && !ce_ok |=> state == st_ignore)
    else $error("select with wrong chip enable accepted");
  a_ignore_quiet: assert property (@(posedge link_clk) disable iff (link_rst)
    state == st_ignore |-> !sda_oe)
    else $error("line driven while ignoring bus");
  a_sda_clk_low: assert property (@(posedge link_clk) disable iff (link_rst)
    $changed(sda_oe) && !$past(start_ev || stop_ev) |-> !$past(scl_s))
    else $error("data line changed while clock high");
  a_count_step: assert property (@(posedge link_clk) disable iff (link_rst)
    rd_rise && cnt == LAST_BIT |=> addr == $past(addr) + 17'h1)
    else $error("address counter not advanced after byte");
  a_nack_ends: assert property (@(posedge link_clk) disable iff (link_rst)
    rd_rise && cnt == ACK_SLOT && sda_s |=> state == st_ignore && !sda_oe)
    else $error("output continued after no acknowledge");
  a_seq_fetch: assert property (@(posedge link_clk) disable iff (link_rst)
    rd_rise && cnt == ACK_SLOT && !sda_s |=> req_tgl != $past(req_tgl) && req.addr == addr)
    else $error("next byte not fetched after acknowledge");
  a_addr_load: assert property (@(posedge link_clk) disable iff (link_rst)
    rx_decide && state == st_addr_lo |=> addr == {sel_a16, addr_hi, $past(shreg)})
    else $error("dummy write did not load counter");
  a_stop_write: assert property (@(posedge link_clk) disable iff (link_rst)
    stop_ev && wr_ok |=> req_tgl != $past(req_tgl) && req.wr)
    else $error("stop after data acknowledge did not start write");
  a_pulse_cancel: assert property (@(posedge link_clk) disable iff (link_rst)
    wr_ok && scl_fall && !rx_done && !start_ev && !stop_ev |=> !wr_ok)
    else $error("extra clock pulse did not cancel pending write");
  a_group_write: assert property (@(posedge ref_clk) disable iff (reset)
    do_write |=> ecc_decode(mem[$past(grp_index)]) == $past(merged) && write_busy)
    else $error("group not rewritten consistently");
  a_single_fix: assert property (@(posedge ref_clk) disable iff (reset)
    do_read |-> ecc_decode(grp_code ^ (38'h1 << req.addr[4:0])) == grp_data)
    else $error("single bit error not corrected");
  a_busy_hold: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(write_busy) |-> write_busy [*2])
    else $error("write cycle shorter than minimum");

  c_seq_read: cover property (@(posedge link_clk) disable iff (link_rst)
    rd_rise && cnt == ACK_SLOT && !sda_s);
  c_poll_refused: cover property (@(posedge link_clk) disable iff (link_rst)
    rx_decide && state == st_select && busy_s);
  c_write_cycle: cover property (@(posedge ref_clk) disable iff (reset) $fell(write_busy));
  c_ce_change: cover property (@(posedge ref_clk) disable iff (reset) $changed(ce_cur));
endmodule

// File: eeprom_rd_pkg.sv
// constants and carrier types for the eeprom read and acknowledge polling block
package eeprom_rd_pkg;
  localparam int          REF_CLK_PERIOD_NS = 20;
  localparam int          ADDR_W            = 17;
  localparam int          GROUPS            = 2 ** (ADDR_W - 2);
  localparam int          CODE_W            = 38;
  localparam int          DATA_W            = 32;
  localparam int          CHECK_W           = 6;
  localparam int          MIN_WRITE_CYCLES  = 2;
  localparam int          SEL_RW_BIT        = 0;
  localparam int          SEL_A16_BIT       = 1;
  localparam int          SEL_CE_LSB        = 2;
  localparam int          SEL_TYPE_LSB      = 4;
  localparam logic [3:0]  DEVICE_TYPE       = 4'ha;
  localparam logic [3:0]  LAST_BIT          = 4'h7;
  localparam logic [3:0]  ACK_SLOT          = 4'h8;
  localparam logic [3:0]  ACK_DONE          = 4'h9;
  localparam logic [1:0]  CE_RESET          = 2'h0;
  localparam logic [31:0] ERASED_WORD       = 32'hffffffff;

  typedef logic [1:0] ce_type;

  typedef struct packed {
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } link_req_type;
endpackage

// File: i2c_ctrl_model.sv
// bus controller model: drives the serial clock and pulls the data line
`timescale 1ns/10ps
module i2c_ctrl_model (
  // timing reference
  input  wire logic ref_clk,
  // bus
  input  wire logic sda_line,
  output logic      scl,
  output logic      host_oe,
  // data line stayed put while the clock was high
  output logic      hold_ok
);
  // 300 ns phases keep the clock low long enough for the read fetch
  localparam int QUARTER = 15;

  initial begin
    scl     = 1'b1;
    host_oe = 1'b0;
    hold_ok = 1'b1;
  end

  task automatic tick();
    repeat (QUARTER) @(posedge ref_clk);
  endtask

  // from idle or with the clock low, so it doubles as a repeated start
  task automatic start_c();
    host_oe <= 1'b0;
    tick();
    scl <= 1'b1;
    tick();
    host_oe <= 1'b1;
    tick();
    scl <= 1'b0;
    tick();
  endtask

  task automatic stop_c();
    host_oe <= 1'b1;
    tick();
    scl <= 1'b1;
    tick();
    host_oe <= 1'b0;
    tick();
    tick();
  endtask

  task automatic bit_c(input logic b, output logic s);
    logic s2;
    host_oe <= ~b;
    tick();
    scl <= 1'b1;
    tick();
    s = sda_line;
    tick();
    s2 = sda_line;
    if (s2 !== s) hold_ok <= 1'b0;
    scl <= 1'b0;
    tick();
  endtask

  task automatic send_byte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_c(v[i], s);
    bit_c(1'b1, s);
    ack = ~s;
  endtask

  task automatic recv_byte(input logic ack_it, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) bit_c(1'b1, v[i]);
    bit_c(~ack_it, s);
  endtask
endmodule

// File: testbench.sv
// self-checking bench: polling, reads, wrap and chip-enable change against a byte model
`timescale 1ns/10ps
module testbench;
  import eeprom_rd_pkg::*;
  logic       ref_clk;
  logic       link_clk;
  logic       reset;
  logic       ce_load;
  ce_type     ce_value;
  ce_type     ce;
  logic       scl;
  logic       host_oe;
  logic       hold_ok;
  logic       sda_out;
  logic       sda_oe;
  logic       write_busy;
  wire        sda_line = (sda_oe ? sda_out : 1'b1) & ~host_oe;
  logic [7:0] mem_model [int];
  int         ctr;
  int         n_mismatch;
  int         comparisons;

  eeprom_read_and_ack_polling #(.WRITE_TIME_NS(30000)) dut_u (
    .ref_clk(ref_clk), .reset(reset), .link_clk(link_clk), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .ce_load(ce_load),
    .ce_value(ce_value), .write_busy(write_busy));
  i2c_ctrl_model m (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl),
    .host_oe(host_oe), .hold_ok(hold_ok));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    link_clk = 1'b0;
    #3.7;
    forever #6 link_clk = ~link_clk;
  end

  task automatic finish_test();
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] want);
    comparisons++;
    if (got !== want) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h want=%h", $time, got, want);
    end
  endtask

  function automatic logic [7:0] expect_at(input int a);
    return mem_model.exists(a) ? mem_model[a] : 8'hff;
  endfunction

  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic select(input logic rw, input logic a16, output logic ack);
    m.send_byte({DEVICE_TYPE, ce, a16, rw}, ack);
  endtask

  task automatic addr_phase(input int a);
    logic ack;
    m.start_c();
    select(1'b0, a[16], ack);
    check(ack, 8'h01);
    m.send_byte(a[15:8], ack);
    check(ack, 8'h01);
    m.send_byte(a[7:0], ack);
    check(ack, 8'h01);
    ctr = a;
  endtask

  // caller has issued the start; the last byte is left unacknowledged
  task automatic read_seq(input int n);
    logic       ack;
    logic [7:0] v;
    select(1'b1, ctr[16], ack);
    check(ack, 8'h01);
    for (int i = 0; i < n; i++) begin
      m.recv_byte(i < n - 1, v);
      check(v, expect_at(ctr));
      ctr = (ctr + 1) % 32'h20000;
    end
    m.stop_c();
  endtask

  task automatic poll();
    logic ack;
    logic b0;
    int   nacks;
    nacks = 0;
    for (int i = 0; i < 20; i++) begin
      b0 = write_busy;
      m.start_c();
      select(1'b0, 1'b0, ack);
      if (b0 && write_busy) check(ack, 8'h00);
      if (!b0 && !write_busy) check(ack, 8'h01);
      if (ack === 1'b1) begin
        check(nacks > 0, 8'h01);
        m.stop_c();
        return;
      end
      nacks++;
      m.send_byte(8'h5a, ack);
      check(ack, 8'h00);
    end
    n_mismatch++;
    finish_test();
  endtask

  task automatic write_byte(input int a, input logic [7:0] d);
    logic ack;
    addr_phase(a);
    m.send_byte(d, ack);
    check(ack, 8'h01);
    m.stop_c();
    mem_model[a] = d;
    poll();
  endtask

  initial begin
    int   a;
    logic ack;
    n_mismatch = 0;
    comparisons = 0;
    reset = 1'b1;
    ce_load = 1'b0;
    ce_value = CE_RESET;
    ce = CE_RESET;
    void'($urandom(32'h48c8ba8a));
    wait_clk(20);
    reset <= 1'b0;
    wait_clk(10);
    write_byte(32'h1ffff, 8'($urandom));
    write_byte(0, 8'($urandom));
    addr_phase(32'h1fffc);
    m.start_c();
    read_seq(6);
    m.start_c();
    read_seq(1);
    $display("test wrap done");
    a = $urandom % 32'h20000;
    write_byte(a, 8'($urandom));
    addr_phase(a);
    m.start_c();
    read_seq(1);
    m.start_c();
    read_seq(2);
    $display("test random read done");
    // a clock pulse between the data acknowledge and stop must cancel the write
    a = (a + 8) % 32'h20000;
    addr_phase(a);
    m.send_byte(8'($urandom), ack);
    check(ack, 8'h01);
    m.send_byte(8'h00, ack);
    check(ack, 8'h00);
    m.stop_c();
    wait_clk(20);
    check(write_busy, 8'h00);
    addr_phase(a);
    m.start_c();
    read_seq(1);
    $display("test cancelled write done");
    ce_load <= 1'b1;
    ce_value <= 2'h1;
    wait_clk(1);
    ce_load <= 1'b0;
    wait_clk(5);
    check(write_busy, 8'h01);
    ce = 2'h1;
    m.start_c();
    select(1'b0, 1'b0, ack);
    check(ack, 8'h00);
    ce = CE_RESET;
    for (int i = 0; i < 20 && write_busy; i++) begin
      m.start_c();
      select(1'b0, 1'b0, ack);
      check(ack, 8'h00);
    end
    m.stop_c();
    check(write_busy, 8'h00);
    m.start_c();
    select(1'b0, 1'b0, ack);
    check(ack, 8'h00);
    ce = 2'h1;
    m.start_c();
    select(1'b0, 1'b0, ack);
    check(ack, 8'h01);
    m.stop_c();
    m.start_c();
    read_seq(1);
    $display("test chip enable change done");
    check(hold_ok, 8'h01);
    finish_test();
  end

  // hang guard well above the expected run length
  initial begin
    wait_clk(95000);
    n_mismatch++;
    finish_test();
  end
endmodule
